// File: remote_prep_pkg.sv
// Constants shared by the remote-control pulse width pre-processor.
// Assumes a single clock that is the main oscillator itself.
// What this block does
// - Reference time from count cycle and offset.
// - Reference time is (16 - n) count cycles.
// - Held count is interval in reference units.
// - Width error up to one reference time.
// - Load-offset bit copies offset into low nibble.
// - Run-enable may share write; counting starts.
// - Load-offset bit self-clears after loading.
// - Low nibble overflow reloads offset automatically.
// - Edge captures upper nibble, restarts counter.
// - Each edge capture raises interrupt request.
// - Further interrupts blocked until count read.
// - Edge-select bit picks rising or falling.
// - Upper nibble all ones: overflow, count F.
// - Run off: falling edge still interrupts.
// - Slow clock on timer forbids long cycle.
// - Low-speed mode stops counting; run-off falling edge still interrupts.
// - Load-offset is command bit zero.
// - Interrupt gated by master and enable register.
package remote_prep_pkg;

    // Register addresses on the command port.
    localparam logic [3:0] addr_offset_value_port   = 4'hd;
    localparam logic [3:0] addr_prep_command_port   = 4'he;
    localparam logic [3:0] addr_captured_count_port = 4'hd;

    // Command register fields.
    localparam int load_offset_bit   = 0;
    localparam int run_enable_bit    = 1;
    localparam int edge_rising_bit   = 2;
    localparam int short_cycle_bit   = 3;

    // Reset values.
    localparam logic [3:0] command_reset = 4'h0;
    localparam logic [3:0] offset_reset  = 4'h0;
    localparam logic [3:0] count_reset   = 4'h0;

    // Count cycles as powers of two of the oscillator period.
    localparam int short_cycle_log2 = 7;
    localparam int long_cycle_log2  = 8;
    localparam logic [7:0] divider_last_long = 8'hff;
    localparam logic [7:0] divider_last_short = 8'h7f;

    // Value that marks an overflow capture.
    localparam logic [3:0] overflow_count = 4'hf;

    // Least input level width, in oscillator periods and in clock cycles.
    localparam int min_level_periods = 192;
    localparam int clock_mhz         = 25;
    localparam int min_level_cycles  = min_level_periods;

endpackage

// File: tick_if.sv
// Link between the pre-processor and its count-cycle divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic run;
    logic short_cycle;
    logic tick;

    modport ctrl (output run, output short_cycle, input tick);
    modport gen  (input run, input short_cycle, output tick);
endinterface
`default_nettype wire

// File: count_tick_gen.sv
// Divider that makes one tick per preset counter count cycle.
// Assumes the clock is the main oscillator.
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen
    import remote_prep_pkg::*;
(
    // Clock and reset.
    input  wire logic i_clock,
    input  wire logic i_nrst,
    // Link to the pre-processor.
    tick_if.gen       link
);

    typedef struct packed {
        logic [7:0] div;
        logic       tick;
    } gen_state_t;

    gen_state_t state;
    gen_state_t next_state;

    // The divider restarts whenever counting stops, so a fresh start gets a full first cycle.
    always_comb begin
        logic [7:0] last;
        last = link.short_cycle ? divider_last_short : divider_last_long;
        next_state = state;
        next_state.tick = 1'b0;
        if (!link.run) begin
            next_state.div = 8'h00;
        end else if (state.div >= last) begin
            next_state.div = 8'h00;
            next_state.tick = 1'b1;
        end else begin
            next_state.div = state.div + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.tick = state.tick;

endmodule
`default_nettype wire

// File: remote_pulse_width_preprocessor.sv
// Remote-control pulse width pre-processor: 8-bit preset counter with capture.
// Assumes the receiver output and all command inputs are synchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module remote_pulse_width_preprocessor
    import remote_prep_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    // Register port.
    input  wire logic [3:0] i_addr,
    input  wire logic [3:0] i_wdata,
    input  wire logic       i_write,
    input  wire logic       i_read,
    output logic      [3:0] o_rdata,
    // Receiver input.
    input  wire logic       i_remote_in,
    // Processor state.
    input  wire logic       i_master_interrupt_enable,
    input  wire logic       i_interrupt_enable_register,
    input  wire logic       i_low_clock_on_timer,
    input  wire logic       i_slow_mode,
    // Interrupt request.
    output logic            o_irq
);

    typedef struct packed {
        logic [3:0] command;
        logic [3:0] offset;
        logic [7:0] counter;
        logic [3:0] count;
        logic       pending;
        logic       overflowed;
        logic       in_prev;
        logic [3:0] rdata;
        logic       irq;
    } prep_state_t;

    prep_state_t state;
    prep_state_t next_state;
    tick_if      tick_link ();

    // Count-cycle divider.
    count_tick_gen u_tick (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .link    (tick_link.gen)
    );

    // The long cycle is not available while the slow clock drives the interval timer.
    assign tick_link.short_cycle = state.command[short_cycle_bit] | i_low_clock_on_timer;
    assign tick_link.run = state.command[run_enable_bit] & ~i_slow_mode;

    // Decodes one strobe aimed at one register index; the write, load and count-read checks go through it, the read-data mux does not.
    function automatic logic hits(input logic strobe, input logic [3:0] addr, input logic [3:0] target);
        return strobe && (addr == target);
    endfunction

    // Next-state logic for the whole pre-processor.
    always_comb begin
        logic rise;
        logic fall;
        logic edge_hit;
        logic count_read;
        logic enabled;
        logic load_now;
        next_state = state;
        next_state.irq = 1'b0;
        next_state.in_prev = i_remote_in;
        rise = i_remote_in & ~state.in_prev;
        fall = ~i_remote_in & state.in_prev;
        edge_hit = state.command[edge_rising_bit] ? rise : fall;
        enabled = i_master_interrupt_enable & i_interrupt_enable_register;
        count_read = hits(i_read, i_addr, addr_captured_count_port);
        load_now = hits(i_write, i_addr, addr_prep_command_port) && i_wdata[load_offset_bit];

        // Read data stand in the cycle after the strobe only.
        next_state.rdata = 4'h0;
        if (i_read) begin
            case (i_addr)
                addr_captured_count_port: next_state.rdata = state.count;
                addr_prep_command_port:   next_state.rdata = state.command;
                default:                  next_state.rdata = 4'h0;
            endcase
        end
        if (count_read) begin
            next_state.pending = 1'b0;
        end

        // Software writes; a load-offset write is consumed at once.
        if (hits(i_write, i_addr, addr_offset_value_port)) begin
            next_state.offset = i_wdata;
        end
        if (hits(i_write, i_addr, addr_prep_command_port)) begin
            next_state.command = i_wdata;
            next_state.command[load_offset_bit] = 1'b0;
            if (i_wdata[load_offset_bit]) begin
                next_state.counter[3:0] = state.offset;
                next_state.overflowed = 1'b0;
            end
        end

        if (tick_link.run && !load_now) begin
            // Edges are ignored while a capture waits to be read, so the held count stays valid.
            if (edge_hit && !state.pending) begin
                // The divider keeps running across an edge, so a width may read one unit long.
                next_state.count = state.counter[7:4];
                next_state.counter = {4'h0, state.offset};
                next_state.overflowed = 1'b0;
                next_state.pending = 1'b1;
                next_state.irq = enabled;
            end else if (tick_link.tick && !state.overflowed) begin
                if (state.counter[3:0] == 4'hf) begin
                    next_state.counter[3:0] = state.offset;
                    next_state.counter[7:4] = state.counter[7:4] + 4'h1;
                    if (state.counter[7:4] == 4'he) begin
                        // Counter parks at the top until the next edge after the count is read, or until a load-offset write.
                        next_state.count = overflow_count;
                        next_state.overflowed = 1'b1;
                        next_state.pending = 1'b1;
                        next_state.irq = enabled && !state.pending;
                    end
                end else begin
                    next_state.counter[3:0] = state.counter[3:0] + 4'h1;
                end
            end
        end else if (!state.command[run_enable_bit] && fall) begin
            next_state.irq = enabled;
        end
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '{command: command_reset, offset: offset_reset, counter: 8'h00,
                       count: count_reset, pending: 1'b0, overflowed: 1'b0,
                       in_prev: 1'b0, rdata: 4'h0, irq: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_irq   = state.irq;

endmodule
`default_nettype wire

// File: remote_rx_model.sv
// Model of the rectified remote-control receiver output.
// Assumes it shares the clock of the pre-processor it feeds.
`timescale 1ns/1ps
`default_nettype none
module remote_rx_model (
    // Clock and receiver line.
    input  wire logic i_clock,
    output var logic  o_level
);
    initial o_level = 1'b0;

    // Sets a new level and holds it; callers keep every level well over 192 cycles.
    task automatic drive(input logic lvl, input int cycles);
        o_level <= lvl;
        repeat (cycles) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// File: remote_prep_sva.sv
// Port checker for the remote pulse width pre-processor.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module remote_prep_sva
    import remote_prep_pkg::*;
(
    // Ports of the watched block.
    input wire logic       i_clock,
    input wire logic       i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [3:0] i_wdata,
    input wire logic       i_write,
    input wire logic       i_read,
    input wire logic [3:0] o_rdata,
    input wire logic       i_remote_in,
    input wire logic       i_master_interrupt_enable,
    input wire logic       i_interrupt_enable_register,
    input wire logic       i_low_clock_on_timer,
    input wire logic       i_slow_mode,
    input wire logic       o_irq
);
    logic run_on;
    wire  en = i_master_interrupt_enable && i_interrupt_enable_register;

    // Mirrors the run-enable bit, since run-off interrupts ignore the unread capture.
    always_ff @(posedge i_clock or negedge i_nrst)
        if (!i_nrst) run_on <= 1'b0;
        else if (i_write && i_addr == addr_prep_command_port) run_on <= i_wdata[run_enable_bit];

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    property p_rdata_idle; !$past(i_read) |-> o_rdata == 4'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_unmapped; $past(i_read) && $past(i_addr) != addr_captured_count_port
        && $past(i_addr) != addr_prep_command_port |-> o_rdata == 4'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_load_clear; $past(i_read) && $past(i_addr) == addr_prep_command_port
        |-> !o_rdata[load_offset_bit]; endproperty
    a_load_clear: assert property (p_load_clear) else $error("load bit reads back set");
    property p_cmd_back; i_write && i_addr == addr_prep_command_port ##1 i_read
        && i_addr == addr_prep_command_port |=> o_rdata[3:1] == $past(i_wdata[3:1], 2); endproperty
    a_cmd_back: assert property (p_cmd_back) else $error("command fields lost");
    property p_irq_pulse; o_irq |=> !o_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
    property p_gate; !en && !$past(en) |-> !o_irq; endproperty
    a_gate: assert property (p_gate) else $error("interrupt while disabled");
    property p_blocked; o_irq && run_on ##1 (!(i_read && i_addr == addr_captured_count_port))[*8]
        |=> !o_irq; endproperty
    a_blocked: assert property (p_blocked) else $error("interrupt before count read");
    property p_run_off; $fell(i_remote_in) && !run_on && en |-> ##[1:3] o_irq; endproperty
    a_run_off: assert property (p_run_off) else $error("no run-off falling edge interrupt");
endmodule
bind remote_pulse_width_preprocessor remote_prep_sva chk (.i_clock, .i_nrst, .i_addr, .i_wdata, .i_write,
    .i_read, .o_rdata, .i_remote_in, .i_master_interrupt_enable, .i_interrupt_enable_register,
    .i_low_clock_on_timer, .i_slow_mode, .o_irq);
`default_nettype wire

// File: tb.sv
// Self-checking bench for the remote pulse width pre-processor.
// Assumes the receiver model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb
    import remote_prep_pkg::*;
;
    logic       i_clock = 1'b0;
    logic       i_nrst = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [3:0] i_wdata = 4'h0;
    logic       i_write = 1'b0;
    logic       i_read = 1'b0;
    logic       i_master_interrupt_enable = 1'b1;
    logic       slow_mode = 1'b0;
    logic       low_clock = 1'b0;
    logic [3:0] o_rdata;
    logic       o_irq;
    logic       remote_level;
    logic [3:0] got;
    logic       sel;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         irqs = 0;
    int         n = 0;

    remote_pulse_width_preprocessor dut (.i_clock, .i_nrst, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
        .i_remote_in(remote_level), .i_master_interrupt_enable, .i_interrupt_enable_register(1'b1),
        .i_low_clock_on_timer(low_clock), .i_slow_mode(slow_mode), .o_irq);
    remote_rx_model rx (.i_clock, .o_level(remote_level));

    // A 25 MHz clock; interrupts are counted on the falling edge to stay clear of the bench's edge.
    always #20 i_clock = ~i_clock;
    always @(negedge i_clock) if (o_irq === 1'b1) irqs++;

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Widths are counted, so a tolerance of one reference time is allowed where asked.
    task automatic chk(input logic [3:0] g, input logic [3:0] e, input int tol);
        cmp_count++;
        if ($isunknown(g) || g + tol < e || g > e + tol) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [3:0] d);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Waits a bounded time for one new interrupt; giving up ends the run.
    task automatic wait_irq(input int lim);
        repeat (lim) if (irqs == n) @(posedge i_clock);
        chk(4'(irqs - n), 4'h1, 0);
        if (irqs == n) give_verdict();
    endtask

    // Both configurations give a reference time of 1024 clocks: short cycle with offset 8, long with 12.
    initial begin
        repeat (6) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        rd(addr_prep_command_port, got);
        chk(got, command_reset, 0);
        rd(4'h3, got);
        chk(got, 4'h0, 0);
        for (int c = 0; c < 2; c++) begin
            sel = (c == 0);
            rx.drive(!sel, 300);
            wr(addr_offset_value_port, c ? 4'hc : 4'h8);
            wr(addr_prep_command_port, c ? 4'h3 : 4'hf);
            rd(addr_prep_command_port, got);
            chk(got, c ? 4'h2 : 4'he, 0);
            // A level change above may have captured; reading clears the block before measuring.
            rd(addr_captured_count_port, got);
            n = irqs;
            rx.drive(sel, 300);
            wait_irq(10);
            rd(addr_captured_count_port, got);
            n = irqs;
            rx.drive(!sel, 2600);
            chk(4'(irqs - n), 4'h0, 0);
            rx.drive(sel, 300);
            wait_irq(10);
            rx.drive(!sel, 300);
            rx.drive(sel, 300);
            chk(4'(irqs - n), 4'h1, 0);
            rd(addr_captured_count_port, got);
            chk(got, 4'h2, 1);
            n = irqs;
            wait_irq(17000);
            rd(addr_captured_count_port, got);
            chk(got, overflow_count, 0);
        end
        // Slow mode stops capture although run is on.
        slow_mode <= 1'b1;
        n = irqs;
        rx.drive(1'b1, 300);
        rx.drive(1'b0, 300);
        chk(4'(irqs - n), 4'h0, 0);
        slow_mode <= 1'b0;
        // With the slow clock on the timer the long cycle halves: 512 clocks per unit.
        low_clock <= 1'b1;
        wr(addr_prep_command_port, 4'h3);
        n = irqs;
        rx.drive(1'b1, 300);
        rx.drive(1'b0, 300);
        wait_irq(10);
        rd(addr_captured_count_port, got);
        n = irqs;
        rx.drive(1'b1, 2600);
        rx.drive(1'b0, 300);
        wait_irq(10);
        rd(addr_captured_count_port, got);
        chk(got, 4'h5, 1);
        low_clock <= 1'b0;
        wr(addr_prep_command_port, 4'h0);
        n = irqs;
        rx.drive(1'b1, 300);
        rx.drive(1'b0, 300);
        chk(4'(irqs - n), 4'h1, 0);
        i_master_interrupt_enable <= 1'b0;
        rx.drive(1'b1, 300);
        rx.drive(1'b0, 300);
        chk(4'(irqs - n), 4'h1, 0);
        give_verdict();
    end
endmodule
`default_nettype wire
